//--- hw/pio_pkg.sv
// constants shared by the parallel port block: port shapes, register
// indices, reset values and bus answers.
// assumes one core clock and a 32-bit AXI4-Lite register bus.
//
// How it works
// - eight ports, 36 pins, separately configured
// - port zero four bits, oscillator pins
// - port one four bits, reset/interrupt/stop pins
// - port two six bits, serial interfaces
// - port four eight bits, analog/key wakeup
// - port seven eight bits, timers, interrupts
// - ports eight, nine, B two bits each
// - port zero lowest two pins never general
// - output pin drives its held output latch
// - pin read returns live level, unlatched
// - pin sampled in read cycle, no strobe
// - written data on pins next cycle
// - direction register picks input or output
// - secondary enable passes peripheral output through
// - drive type picks push-pull or open-drain
// - pull-up only for inputs or open-drain
// - each port has only relevant registers

package pio_pkg;

    // ***************************************************************
    // port shapes
    // ***************************************************************
    localparam int PIO_NPORT = 8;
    localparam int PIO_NPIN = 36;
    localparam int PIO_DW = 8; // width of every port register
    // index order: p0, p1, p2, p4, p7, p8, p9, pb
    localparam int PIO_PORT_W [PIO_NPORT] = '{4, 4, 6, 8, 8, 2, 2, 2};
    localparam int PIO_PORT_LSB [PIO_NPORT] = '{0, 0, 0, 0, 0, 0, 0, 4};
    localparam int PIO_PIN_BASE [PIO_NPORT] = '{0, 4, 8, 14, 22, 30, 32, 34};
    localparam int PIO_IDX_P0 = 0;
    localparam int PIO_IDX_P2 = 2;
    localparam int PIO_IDX_P4 = 3;
    // general pins per port; p0 bits 1:0 belong to the oscillator
    localparam logic [7:0] PIO_P0_GP = 8'h0c;
    localparam logic [7:0] PIO_ALL_GP = 8'hff;
    // which optional registers exist, bit n for port index n
    localparam logic [7:0] PIO_HAS_SEC = 8'hfd;
    localparam logic [7:0] PIO_HAS_ODT = 8'hf4;
    localparam logic [7:0] PIO_HAS_PU = 8'hfe;

    // ***************************************************************
    // register indices; byte address = {port, index, 2'b00}
    // ***************************************************************
    localparam logic [2:0] PIO_REG_LATCH = 3'h0;
    localparam logic [2:0] PIO_REG_PIN = 3'h1;
    localparam logic [2:0] PIO_REG_DIR = 3'h2;
    localparam logic [2:0] PIO_REG_SEC = 3'h3;
    localparam logic [2:0] PIO_REG_ODT = 3'h4;
    localparam logic [2:0] PIO_REG_PU = 3'h5;
    localparam logic [7:0] PIO_RST_VAL = 8'h00;

    // ***************************************************************
    // bus answers
    // ***************************************************************
    localparam logic [1:0] PIO_RESP_OKAY = 2'h0;
    localparam logic [1:0] PIO_RESP_SLVERR = 2'h2;

endpackage

//--- hw/pio_port_regs.sv
// one port's control registers; absent registers read as zero.
// assumes the caller qualifies wr_en with address decode.
`timescale 1ns/1ps
`default_nettype none

module pio_port_regs
    import pio_pkg::*;
#(
    parameter int W = 4, // pins in this port
    parameter int LSB = 0, // register bit of the lowest pin
    parameter logic [7:0] GP = 8'hff, // general purpose pins
    parameter bit HAS_SEC = 1'b1,
    parameter bit HAS_ODT = 1'b1,
    parameter bit HAS_PU = 1'b1
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic [2:0] wr_reg,
    input wire logic [7:0] wr_data,
    output logic [7:0] latch_reg,
    output logic [7:0] dir_reg,
    output logic [7:0] sec_reg,
    output logic [7:0] odt_reg,
    output logic [7:0] pu_reg
);

    // ***************************************************************
    // masks of implemented bits
    // ***************************************************************
    localparam logic [7:0] BITS = 8'(((1 << W) - 1) << LSB);
    localparam logic [7:0] DIR_M = BITS & GP;
    localparam logic [7:0] SEC_M = HAS_SEC ? BITS : 8'h00;
    localparam logic [7:0] ODT_M = HAS_ODT ? BITS : 8'h00;
    localparam logic [7:0] PU_M = HAS_PU ? BITS : 8'h00;

    if (W < 1 || LSB + W > PIO_DW) begin : g_bad_shape
        $error("pio_port_regs: port slice does not fit the register");
    end

    // output latch holds until the next write
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            latch_reg <= PIO_RST_VAL;
        end else if (wr_en && wr_reg == PIO_REG_LATCH) begin
            latch_reg <= wr_data & BITS;
        end
    end

    // direction, reset to input so nothing drives early
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            dir_reg <= PIO_RST_VAL;
        end else if (wr_en && wr_reg == PIO_REG_DIR) begin
            dir_reg <= wr_data & DIR_M;
        end
    end

    // secondary output enable
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sec_reg <= PIO_RST_VAL;
        end else if (wr_en && wr_reg == PIO_REG_SEC) begin
            sec_reg <= wr_data & SEC_M;
        end
    end

    // drive type: 1 open-drain, 0 push-pull
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            odt_reg <= PIO_RST_VAL;
        end else if (wr_en && wr_reg == PIO_REG_ODT) begin
            odt_reg <= wr_data & ODT_M;
        end
    end

    // pull-up select
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pu_reg <= PIO_RST_VAL;
        end else if (wr_en && wr_reg == PIO_REG_PU) begin
            pu_reg <= wr_data & PU_M;
        end
    end

endmodule // pio_port_regs

`default_nettype wire

//--- hw/pio_port_pins.sv
// pad-side drive logic of one port: value, enable and pull-up.
// assumes the pad merges pin_o/pin_oe with the external level.
`timescale 1ns/1ps
`default_nettype none

module pio_port_pins #(
    parameter int W = 4 // pins in this port
) (
    input wire logic [W-1:0] latch,
    input wire logic [W-1:0] dir,
    input wire logic [W-1:0] sec,
    input wire logic [W-1:0] odt,
    input wire logic [W-1:0] pu,
    input wire logic [W-1:0] periph_o,
    output logic [W-1:0] pin_o,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] pin_pu
);

    logic [W-1:0] val; // level the pin should show when driven

    if (W < 1) begin : g_bad_width
        $error("pio_port_pins: a port needs at least one pin");
    end

    // peripheral replaces the latch where its enable is set
    assign val = (sec & periph_o) | (~sec & latch);
    // open-drain only pulls low; push-pull drives both levels
    assign pin_oe = dir & ~(odt & val);
    assign pin_o = val & ~odt;
    // pull-up matters only while nothing drives high
    assign pin_pu = pu & (~dir | odt);

endmodule // pio_port_pins

`default_nettype wire

//--- hw/pio_ports.sv
// top of the parallel port block: AXI4-Lite slave, register decode,
// eight port slices and the live pin read path.
// assumes pins are synchronous to core_clk and the pad cells resolve
// pin_o, pin_oe and pin_pu into the wire level seen on pin_i.
//
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pio_ports
    import pio_pkg::*;
#(
    parameter int A_W = 8 // bus address width
) (
    input wire logic core_clk,
    input wire logic resetn,
    // write address channel
    input wire logic [A_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [A_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pins, flat: p0 at 3:0 up to pb at 35:34
    input wire logic [PIO_NPIN-1:0] pin_i,
    output logic [PIO_NPIN-1:0] pin_o,
    output logic [PIO_NPIN-1:0] pin_oe,
    output logic [PIO_NPIN-1:0] pin_pu,
    // shared peripherals' outputs, same pin order
    input wire logic [PIO_NPIN-1:0] periph_o
);

    // ***************************************************************
    // shape checks
    // ***************************************************************
    function automatic int total_pins();
        int s;
        s = 0;
        for (int p = 0; p < PIO_NPORT; p++) begin
            s += PIO_PORT_W[p];
        end
        return s;
    endfunction

    if (total_pins() != PIO_NPIN) begin : g_bad_total
        $error("pio_ports: port widths do not add up to the pin count");
    end
    if (A_W < 8) begin : g_bad_addr
        $error("pio_ports: address too narrow for the register map");
    end

    // ***************************************************************
    // address decode
    // ***************************************************************
    // true when the address names a register that exists; an absent
    // register answers with an error rather than silently reading 0
    function automatic logic reg_exists(input logic [A_W-1:0] a);
        logic [2:0] p;
        logic [2:0] r;
        logic ok;
        p = a[7:5];
        r = a[4:2];
        // shifting rather than slicing keeps this legal when A_W is 8
        ok = (a[1:0] == 2'h0) && ((a >> 8) == '0);
        unique case (r)
            PIO_REG_LATCH, PIO_REG_PIN, PIO_REG_DIR: ok = ok;
            PIO_REG_SEC: ok = ok && PIO_HAS_SEC[p];
            PIO_REG_ODT: ok = ok && PIO_HAS_ODT[p];
            PIO_REG_PU: ok = ok && PIO_HAS_PU[p];
            default: ok = 1'b0; // indices 6 and 7 are holes
        endcase
        return ok;
    endfunction

    // ***************************************************************
    // write path
    // ***************************************************************
    logic aw_got_reg; // address captured
    logic [A_W-1:0] aw_addr_reg;
    logic w_got_reg; // data captured
    logic [7:0] w_data_reg; // only the low lane carries port data
    logic w_lane_reg; // byte lane 0 was enabled
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic wr_go; // both halves held, response slot free
    logic wr_hit; // wr_go to an existing register with lane 0 enabled
    logic [2:0] wr_port;
    logic [2:0] wr_sel;

    // accept each half independently, one write in flight
    assign s_axi_awready = !aw_got_reg && !bvalid_reg;
    assign s_axi_wready = !w_got_reg && !bvalid_reg;
    assign wr_go = aw_got_reg && w_got_reg && !bvalid_reg;
    assign wr_port = aw_addr_reg[7:5];
    assign wr_sel = aw_addr_reg[4:2];
    assign wr_hit = wr_go && reg_exists(aw_addr_reg) && w_lane_reg;

    // write address holding register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            aw_got_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_got_reg <= 1'b0;
        end
    end

    // write data holding register
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            w_got_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_lane_reg <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_lane_reg <= s_axi_wstrb[0];
        end else if (wr_go) begin
            w_got_reg <= 1'b0;
        end
    end

    // write response, held until the master takes it
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= PIO_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_reg <= 1'b1;
            // a write with lane 0 off is harmless, answered OKAY
            bresp_reg <= reg_exists(aw_addr_reg) ? PIO_RESP_OKAY
                                                 : PIO_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // ***************************************************************
    // port slices
    // ***************************************************************
    logic [7:0] latch_q [PIO_NPORT];
    logic [7:0] dir_q [PIO_NPORT];
    logic [7:0] sec_q [PIO_NPORT];
    logic [7:0] odt_q [PIO_NPORT];
    logic [7:0] pu_q [PIO_NPORT];
    logic [7:0] pin_rd [PIO_NPORT]; // live pins at register position

    for (genvar g = 0; g < PIO_NPORT; g++) begin : g_port
        localparam int W = PIO_PORT_W[g];
        localparam int L = PIO_PORT_LSB[g];
        localparam int B = PIO_PIN_BASE[g];
        localparam logic [7:0] GP = (g == PIO_IDX_P0) ? PIO_P0_GP
                                                      : PIO_ALL_GP;
        logic [7:0] rd_full; // this port's pins at register position
        logic wr_this; // a write aimed at this port

        // only a decoded, existing register of this port is written
        assign wr_this = wr_hit && (wr_port == 3'(g));

        // control registers; absent ones stay zero through their masks
        pio_port_regs #(
            .W(W),
            .LSB(L),
            .GP(GP),
            .HAS_SEC(PIO_HAS_SEC[g]),
            .HAS_ODT(PIO_HAS_ODT[g]),
            .HAS_PU(PIO_HAS_PU[g])
        ) u_regs (
            .core_clk(core_clk),
            .resetn(resetn),
            .wr_en(wr_this),
            .wr_reg(wr_sel),
            .wr_data(w_data_reg),
            .latch_reg(latch_q[g]),
            .dir_reg(dir_q[g]),
            .sec_reg(sec_q[g]),
            .odt_reg(odt_q[g]),
            .pu_reg(pu_q[g])
        );

        // pad drive of this port's slice of the flat pin vector
        pio_port_pins #(
            .W(W)
        ) u_pins (
            .latch(latch_q[g][L +: W]),
            .dir(dir_q[g][L +: W]),
            .sec(sec_q[g][L +: W]),
            .odt(odt_q[g][L +: W]),
            .pu(pu_q[g][L +: W]),
            .periph_o(periph_o[B +: W]),
            .pin_o(pin_o[B +: W]),
            .pin_oe(pin_oe[B +: W]),
            .pin_pu(pin_pu[B +: W])
        );

        // live pin levels at the register bits; no input latch, so
        // a bouncing input must be filtered by software
        always_comb begin
            rd_full = 8'h00;
            rd_full[L +: W] = pin_i[B +: W];
        end

        assign pin_rd[g] = rd_full;
    end

    // ***************************************************************
    // read path
    // ***************************************************************
    logic rvalid_reg; // read answer waiting for the master
    logic [1:0] rresp_reg;
    logic [31:0] rdata_reg;
    logic rd_take; // read address accepted this cycle
    logic [2:0] rd_port;
    logic [2:0] rd_sel;
    logic [7:0] rd_word; // selected register, zero when absent

    // one read in flight: a new address waits for the answer to go
    assign s_axi_arready = !rvalid_reg;
    assign rd_take = s_axi_arvalid && s_axi_arready;
    assign rd_port = s_axi_araddr[7:5];
    assign rd_sel = s_axi_araddr[4:2];

    // register select straight from the offered address
    always_comb begin
        rd_word = 8'h00;
        if (reg_exists(s_axi_araddr)) begin
            unique case (rd_sel)
                PIO_REG_LATCH: rd_word = latch_q[rd_port];
                PIO_REG_PIN: rd_word = pin_rd[rd_port];
                PIO_REG_DIR: rd_word = dir_q[rd_port];
                PIO_REG_SEC: rd_word = sec_q[rd_port];
                PIO_REG_ODT: rd_word = odt_q[rd_port];
                PIO_REG_PU: rd_word = pu_q[rd_port];
                default: rd_word = 8'h00; // holes read as zero
            endcase
        end
    end

    // read answer; the pins are sampled at the accepting edge, which
    // is the read cycle, and nothing outside marks that moment
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg <= PIO_RESP_OKAY;
            rdata_reg <= 32'h0000_0000;
        end else if (rd_take) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= reg_exists(s_axi_araddr) ? PIO_RESP_OKAY
                                                  : PIO_RESP_SLVERR;
            rdata_reg <= {24'h00_0000, rd_word};
        end else if (s_axi_rready) begin
            // answer taken, or nothing was pending
            rvalid_reg <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;

    // ***************************************************************
    // assertions
    // ***************************************************************
    // read address taken
    sequence s_ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // read answer offered
    sequence s_r_answer;
        s_axi_rvalid;
    endsequence

    // a write to port four's output latch
    sequence s_latch_wr;
        wr_hit && (wr_sel == PIO_REG_LATCH)
            && (wr_port == 3'(PIO_IDX_P4));
    endsequence

    // an accepted read is answered at the very next edge
    property p_ar_answer;
        @(posedge core_clk) disable iff (!resetn)
            s_ar_take |=> s_r_answer;
    endproperty
    a_ar_answer: assert property (p_ar_answer)
        else $error("read address taken but no answer followed");

    // a pending read answer stands unchanged until taken
    property p_r_hold;
        @(posedge core_clk) disable iff (!resetn)
            (s_axi_rvalid && !s_axi_rready)
                |=> (s_axi_rvalid && $stable(s_axi_rdata));
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read answer changed before it was taken");

    // a pending write answer stands unchanged until taken
    property p_b_hold;
        @(posedge core_clk) disable iff (!resetn)
            (s_axi_bvalid && !s_axi_bready)
                |=> (s_axi_bvalid && $stable(s_axi_bresp));
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write answer changed before it was taken");

    // written data holds in the latch from the next cycle on
    property p_wr_next;
        @(posedge core_clk) disable iff (!resetn)
            s_latch_wr |=> (latch_q[PIO_IDX_P4] == $past(w_data_reg));
    endproperty
    a_wr_next: assert property (p_wr_next)
        else $error("latch write did not land in the next cycle");

    // nothing drives in the cycle after reset
    property p_rst_quiet;
        @(posedge core_clk) !resetn |=> (pin_oe == '0);
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("a pin drives right after reset");

    // oscillator pins of port zero never drive
    property p_osc_quiet;
        @(posedge core_clk) disable iff (!resetn)
            pin_oe[1:0] == 2'b00;
    endproperty
    a_osc_quiet: assert property (p_osc_quiet)
        else $error("an oscillator pin is driven");

    // pull-up never joins a pad that drives high itself
    property p_pu_gate;
        @(posedge core_clk) disable iff (!resetn)
            (pin_pu & pin_oe & pin_o) == '0;
    endproperty
    a_pu_gate: assert property (p_pu_gate)
        else $error("pull-up on while the pad drives high");

endmodule // pio_ports

`default_nettype wire

//--- verification/pio_pin_model.sv
// board side of the port pins: resolves each wire from pads and board.
// assumes pads give pin_o/pin_oe/pin_pu; the bench supplies board drive.
`timescale 1ns/1ps
`default_nettype none

module pio_pin_model
    import pio_pkg::*;
(
    input wire logic [PIO_NPIN-1:0] pin_o,
    input wire logic [PIO_NPIN-1:0] pin_oe,
    input wire logic [PIO_NPIN-1:0] pin_pu,
    input wire logic [PIO_NPIN-1:0] ext_val, // board drive level
    input wire logic [PIO_NPIN-1:0] ext_en, // board drives the wire
    output logic [PIO_NPIN-1:0] pin_i
);
    // pad wins, then board, then pull-up, else the inverse of the
    // pad value so a released wire never keeps its last level
    always_comb begin
        for (int i = 0; i < PIO_NPIN; i++) begin
            if (pin_oe[i]) begin
                pin_i[i] = pin_o[i];
            end else if (ext_en[i]) begin
                pin_i[i] = ext_val[i];
            end else begin
                pin_i[i] = pin_pu[i] | ~pin_o[i];
            end
        end
    end
endmodule // pio_pin_model
`default_nettype wire

//--- verification/testbench.sv
// self-checking bench of the parallel port block over AXI4-Lite.
// assumes the pin model stands on the far side of every pin.
`timescale 1ns/1ps
`default_nettype none

module testbench
    import pio_pkg::*;
;
    // ***************************************************************
    // signals
    // ***************************************************************
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [PIO_NPIN-1:0] pin_i, pin_o, pin_oe, pin_pu;
    logic [PIO_NPIN-1:0] periph_o = '0, ext_val = '0, ext_en = '0;
    int miscompares = 0;
    int num_checks = 0;
    logic [31:0] rd;
    logic [1:0] rsp;

    initial begin
        forever #2.5 core_clk = ~core_clk;
    end

    pio_ports dut (.core_clk(core_clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .pin_pu(pin_pu), .periph_o(periph_o));

    pio_pin_model board (.pin_o(pin_o),
        .pin_oe(pin_oe), .pin_pu(pin_pu), .ext_val(ext_val),
        .ext_en(ext_en), .pin_i(pin_i));

    // ***************************************************************
    // bus tasks and checks
    // ***************************************************************
    function automatic logic [7:0] adr(int p, logic [2:0] r);
        return {p[2:0], r, 2'b00};
    endfunction

    task automatic chk(logic [63:0] got, logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // both channels offered together, each dropped when taken
    task automatic wr(int p, logic [2:0] r, logic [7:0] d);
        int n;
        n = 0;
        // start on an edge so bready is never set twice in one step
        @(posedge core_clk);
        awaddr <= adr(p, r);
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bready && bvalid) && n < 200);
        rsp = bresp;
        bready <= 1'b0;
        if (n >= 200) miscompares++;
    endtask

    task automatic rdr(int p, logic [2:0] r);
        int n;
        n = 0;
        @(posedge core_clk);
        araddr <= adr(p, r);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rready && rvalid) && n < 200);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
        if (n >= 200) miscompares++;
    endtask

    // let the edge after the write land before looking at pins
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // hang guard, far beyond the hundred or so cycles of the tests
    initial begin
        #100000;
        miscompares++;
        results();
    end

    // ***************************************************************
    // tests
    // ***************************************************************
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        for (int p = 0; p < PIO_NPORT; p++) begin
            rdr(p, PIO_REG_DIR);
            chk(rd, 0);
        end
        chk(pin_oe, 0);
        $display("test reset done");
        // port four as output; latch drives the pins
        wr(PIO_IDX_P4, PIO_REG_LATCH, 8'h96);
        wr(PIO_IDX_P4, PIO_REG_DIR, 8'hff);
        settle();
        chk(pin_oe[21:14], 8'hff);
        chk(pin_o[21:14], 8'h96);
        wr(PIO_IDX_P4, PIO_REG_LATCH, 8'h69);
        settle();
        chk(pin_o[21:14], 8'h69);
        rdr(PIO_IDX_P4, PIO_REG_LATCH);
        chk(rd[7:0], 8'h69);
        // peripheral takes over the output, then hands back
        periph_o[21:14] <= 8'h3c;
        wr(PIO_IDX_P4, PIO_REG_SEC, 8'hff);
        settle();
        chk(pin_o[21:14], 8'h3c);
        wr(PIO_IDX_P4, PIO_REG_SEC, 8'h00);
        settle();
        chk(pin_o[21:14], 8'h69);
        $display("test output done");
        // port seven as input; the level is live, not held
        ext_en[29:22] <= 8'hff;
        ext_val[29:22] <= 8'ha5;
        rdr(4, PIO_REG_PIN);
        chk(rd[7:0], 8'ha5);
        ext_val[29:22] <= 8'h5a;
        rdr(4, PIO_REG_PIN);
        chk(rd[7:0], 8'h5a);
        $display("test input done");
        // oscillator pins of port zero never drive
        wr(PIO_IDX_P0, PIO_REG_LATCH, 8'hff);
        wr(PIO_IDX_P0, PIO_REG_DIR, 8'hff);
        settle();
        chk(pin_oe[3:0], 4'hc);
        // port B sits at register bits 5:4
        wr(7, PIO_REG_LATCH, 8'h30);
        wr(7, PIO_REG_DIR, 8'h30);
        settle();
        chk({pin_oe[35:34], pin_o[35:34]}, 4'hf);
        $display("test shape done");
        // pull-up for input and open drain only
        wr(PIO_IDX_P2, PIO_REG_PU, 8'hff);
        settle();
        chk(pin_pu[13:8], 6'h3f);
        wr(PIO_IDX_P2, PIO_REG_DIR, 8'hff);
        settle();
        chk(pin_pu[13:8], 6'h00);
        wr(PIO_IDX_P2, PIO_REG_ODT, 8'hff);
        settle();
        chk(pin_pu[13:8], 6'h3f);
        $display("test pullup done");
        // port one has no secondary enable; unmapped index refused
        wr(1, PIO_REG_SEC, 8'hff);
        chk(rsp, PIO_RESP_SLVERR);
        rdr(1, PIO_REG_SEC);
        chk(rd, 0);
        rdr(0, 3'h7);
        chk(rsp, PIO_RESP_SLVERR);
        $display("test absent done");
        results();
    end
endmodule // testbench
`default_nettype wire
